// ---- hdl/uart_flow_pkg.sv ----
/*
 Constants, register map, field positions and carrier types of the UART flow-control block.
 Assumes a 64-entry receive FIFO whose fill level arrives as a 7-bit count from 0 to 64.
*/
`default_nettype none

package uart_flow_pkg;

   localparam int LVL_W = 7;
   localparam int ADDR_W = 4;

   // Register offsets on the plain register port
   localparam logic [3:0] ADDR_FIFO_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_TRIGGER_LEVEL = 4'h1;
   localparam logic [3:0] ADDR_TRANSMISSION_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_ENHANCED_FEATURE = 4'h3;
   localparam logic [3:0] ADDR_MODEM_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_INTERRUPT_ENABLE = 4'h5;
   localparam logic [3:0] ADDR_INTERRUPT_IDENT = 4'h6;
   localparam logic [3:0] ADDR_PAUSE_FIRST = 4'h7;
   localparam logic [3:0] ADDR_PAUSE_SECOND = 4'h8;
   localparam logic [3:0] ADDR_RESUME_FIRST = 4'h9;
   localparam logic [3:0] ADDR_RESUME_SECOND = 4'hA;
   localparam logic [3:0] ADDR_FLOW_STATUS = 4'hB;

   // Field positions
   localparam int FIFO_ENABLE = 0;
   localparam int FIFO_TX_SEL = 4;
   localparam int FIFO_RX_SEL = 6;
   localparam int TRIG_TX = 0;
   localparam int TRIG_RX = 4;
   localparam int LVL_HALT = 0;
   localparam int LVL_RESUME = 4;
   localparam int FEAT_RX_FLOW = 0;
   localparam int FEAT_TX_FLOW = 2;
   localparam int FEAT_SPECIAL = 5;
   localparam int FEAT_AUTO_RTS = 6;
   localparam int FEAT_AUTO_CTS = 7;
   localparam int MODEM_RTS = 1;
   localparam int MODEM_ANY_RESUME = 5;
   localparam int IRQ_EN_PAUSE = 5;

   // Software flow selections
   localparam logic [1:0] FLOW_NONE = 2'h0;
   localparam logic [1:0] FLOW_SECOND = 2'h1;
   localparam logic [1:0] FLOW_FIRST = 2'h2;
   localparam logic [1:0] FLOW_BOTH = 2'h3;

   // Level tables, indexed by the two-bit selectable field
   localparam logic [3:0][6:0] RX_SEL_LVL = {7'h3C, 7'h38, 7'h10, 7'h08};
   localparam logic [3:0][6:0] RX_LOW_LVL = {7'h38, 7'h10, 7'h08, 7'h00};
   localparam logic [3:0][6:0] TX_SEL_LVL = {7'h38, 7'h20, 7'h10, 7'h08};
   localparam logic [6:0] LVL_ONE = 7'h01;

   localparam logic [7:0] IDENT_NONE = 8'h01;
   localparam logic [7:0] IDENT_PAUSE = 8'h10;

   typedef enum logic [1:0] {SEND_IDLE, SEND_FIRST, SEND_SECOND} send_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic start;
      logic from_fifo;
      logic [7:0] data;
   } tx_cmd_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rx_char_t;

   // Nibble level in steps of four characters
   function automatic logic [6:0] nibble_lvl(input logic [3:0] n);
      nibble_lvl = {1'b0, n, 2'b00};
   endfunction : nibble_lvl

   // Low-order bits kept for word lengths 5 to 8
   function automatic logic [7:0] char_mask(input logic [1:0] wlen);
      case (wlen)
         2'h0: char_mask = 8'h1F;
         2'h1: char_mask = 8'h3F;
         2'h2: char_mask = 8'h7F;
         default: char_mask = 8'hFF;
      endcase
   endfunction : char_mask

endpackage : uart_flow_pkg

`default_nettype wire

// ---- hdl/uart_flow_control.sv ----
/*
 Flow-control logic of a single-channel UART: trigger levels, automatic RTS/CTS handshake,
 software pause/resume characters, special character detection and the pause interrupt flag.
 Assumes transmitter, receiver and FIFOs on the same clock; cts_n arrives from a pin.
*/
// What this block does
// - FIFOs disabled after reset, trigger one character
// - Independent triggers; zero programmable falls back selectable
// - Auto CTS and auto RTS enabled separately
// - Bit 6 auto RTS, bit 7 auto CTS
// - Auto CTS: FIFO bytes start only while CTS low
// - RTS active below halt level, drops there
// - RTS returns at resume level after halting
// - Halt and resume fields both zero use selectable levels
// - Still accept one late character after halt
// - CTS sampled before each FIFO byte; current finishes
// - CTS back low resumes queued characters
// - No CTS interrupts under auto; else ignore CTS
// - Transmit pause/resume selection by bits 3:2
// - Receive comparison selection by bits 1:0
// - Any character but a pause resumes after pause when enabled
// - First and second resume both taken when compared; neither stored
// - Special character flags, stored, ident read clears
// - Pause character stops transmitter, sets flag, interrupt
// - Resume characters restart transmitter, clear flag
// - Send pause when fill passes halt level
// - Send resume when fill reaches resume level
// - Flow characters framed as data, masked width
// - Pause and resume characters survive every reset
`default_nettype none

module uart_flow_control
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire uart_flow_pkg::reg_req_t req,
   output logic [7:0] rdata,
   input wire logic [1:0] word_len,
   input wire logic [uart_flow_pkg::LVL_W-1:0] rx_fifo_level,
   input wire logic tx_fifo_empty,
   input wire logic tx_ready,
   output uart_flow_pkg::tx_cmd_t tx_cmd,
   input wire uart_flow_pkg::rx_char_t rx_in,
   output uart_flow_pkg::rx_char_t rx_store,
   input wire logic cts_n,
   output logic rts_n,
   output logic pause_irq_n,
   output logic modem_irq_allow,
   output logic [uart_flow_pkg::LVL_W-1:0] rx_trig_lvl,
   output logic [uart_flow_pkg::LVL_W-1:0] tx_trig_lvl
);
   import uart_flow_pkg::*;

   typedef struct packed {
      logic [7:0] fifo_ctl;
      logic [7:0] trig_cfg;
      logic [7:0] flow_lvl;
      logic [7:0] feat;
      logic [7:0] modem;
      logic [7:0] irq_en;
      logic [7:0] pause1;
      logic [7:0] pause2;
      logic [7:0] resume1;
      logic [7:0] resume2;
      logic cts_s1;
      logic cts_s2;
      logic rts_act;
      logic rts_n;
      logic remote_paused;
      logic local_paused;
      logic pause_half;
      logic resume_half;
      logic flag;
      logic flag_special;
      send_t send_st;
      logic send_pause;
      tx_cmd_t tx;
      rx_char_t store;
      logic [7:0] rdata;
      logic [6:0] rx_trig;
      logic [6:0] tx_trig;
   } st_t;

   st_t st_q;
   st_t st_d;

   logic auto_cts;
   logic auto_rts;
   logic cts_seen;
   logic cts_ok;
   logic [6:0] halt_lvl;
   logic [6:0] resume_lvl;
   logic [1:0] tx_mode;
   logic [1:0] rx_mode;
   logic [7:0] mask;
   logic [7:0] rx_c;
   logic seq_mode;
   logic use_first;
   logic use_second;
   logic pause_hit;
   logic resume_hit;
   logic special_hit;
   logic consume;
   logic iir_read;
   logic [7:0] flow_char;

   assign auto_cts = st_q.feat[FEAT_AUTO_CTS];
   assign auto_rts = st_q.feat[FEAT_AUTO_RTS];
   assign cts_seen = st_q.cts_s2;
   assign tx_mode = st_q.feat[FEAT_TX_FLOW +: 2];
   assign rx_mode = st_q.feat[FEAT_RX_FLOW +: 2];

   always_comb
   begin
      st_d = st_q;
      st_d.tx.start = 1'b0;
      st_d.store.valid = 1'b0;
      st_d.rdata = 8'h00;
      mask = char_mask(word_len);
      rx_c = rx_in.data & mask;
      iir_read = req.rd && (req.addr == ADDR_INTERRUPT_IDENT);

      // Register writes
      if (req.wr)
      begin
         if (req.addr == ADDR_FIFO_CONTROL)
            st_d.fifo_ctl = req.wdata;
         else if (req.addr == ADDR_TRIGGER_LEVEL)
            st_d.trig_cfg = req.wdata;
         else if (req.addr == ADDR_TRANSMISSION_CONTROL)
            st_d.flow_lvl = req.wdata;
         else if (req.addr == ADDR_ENHANCED_FEATURE)
            st_d.feat = req.wdata;
         else if (req.addr == ADDR_MODEM_CONTROL)
            st_d.modem = req.wdata;
         else if (req.addr == ADDR_INTERRUPT_ENABLE)
            st_d.irq_en = req.wdata;
         else if (req.addr == ADDR_PAUSE_FIRST)
            st_d.pause1 = req.wdata;
         else if (req.addr == ADDR_PAUSE_SECOND)
            st_d.pause2 = req.wdata;
         else if (req.addr == ADDR_RESUME_FIRST)
            st_d.resume1 = req.wdata;
         else if (req.addr == ADDR_RESUME_SECOND)
            st_d.resume2 = req.wdata;
      end

      // Register reads, data one cycle later
      if (req.rd)
      begin
         if (req.addr == ADDR_FIFO_CONTROL)
            st_d.rdata = st_q.fifo_ctl;
         else if (req.addr == ADDR_TRIGGER_LEVEL)
            st_d.rdata = st_q.trig_cfg;
         else if (req.addr == ADDR_TRANSMISSION_CONTROL)
            st_d.rdata = st_q.flow_lvl;
         else if (req.addr == ADDR_ENHANCED_FEATURE)
            st_d.rdata = st_q.feat;
         else if (req.addr == ADDR_MODEM_CONTROL)
            st_d.rdata = st_q.modem;
         else if (req.addr == ADDR_INTERRUPT_ENABLE)
            st_d.rdata = st_q.irq_en;
         else if (req.addr == ADDR_INTERRUPT_IDENT)
            st_d.rdata = (st_q.flag && st_q.irq_en[IRQ_EN_PAUSE]) ? IDENT_PAUSE : IDENT_NONE;
         else if (req.addr == ADDR_PAUSE_FIRST)
            st_d.rdata = st_q.pause1;
         else if (req.addr == ADDR_PAUSE_SECOND)
            st_d.rdata = st_q.pause2;
         else if (req.addr == ADDR_RESUME_FIRST)
            st_d.rdata = st_q.resume1;
         else if (req.addr == ADDR_RESUME_SECOND)
            st_d.rdata = st_q.resume2;
         else if (req.addr == ADDR_FLOW_STATUS)
            st_d.rdata = {st_q.flag, st_q.flag_special, st_q.local_paused, st_q.remote_paused,
                          st_q.rts_act, cts_seen, st_q.pause_half, st_q.resume_half};
      end

      // CTS pin synchroniser
      st_d.cts_s1 = cts_n;
      st_d.cts_s2 = st_q.cts_s1;

      // Interrupt trigger levels
      if (!st_q.fifo_ctl[FIFO_ENABLE])
      begin
         st_d.rx_trig = LVL_ONE;
         st_d.tx_trig = LVL_ONE;
      end
      else
      begin
         st_d.rx_trig = (st_q.trig_cfg[TRIG_RX +: 4] != 4'h0) ? nibble_lvl(st_q.trig_cfg[TRIG_RX +: 4])
                        : RX_SEL_LVL[st_q.fifo_ctl[FIFO_RX_SEL +: 2]];
         st_d.tx_trig = (st_q.trig_cfg[TRIG_TX +: 4] != 4'h0) ? nibble_lvl(st_q.trig_cfg[TRIG_TX +: 4])
                        : TX_SEL_LVL[st_q.fifo_ctl[FIFO_TX_SEL +: 2]];
      end

      // Halt and resume levels
      if (st_q.flow_lvl == 8'h00)
      begin
         halt_lvl = RX_SEL_LVL[st_q.fifo_ctl[FIFO_RX_SEL +: 2]];
         resume_lvl = RX_LOW_LVL[st_q.fifo_ctl[FIFO_RX_SEL +: 2]];
      end
      else
      begin
         halt_lvl = nibble_lvl(st_q.flow_lvl[LVL_HALT +: 4]);
         resume_lvl = nibble_lvl(st_q.flow_lvl[LVL_RESUME +: 4]);
      end

      // Automatic RTS, halt wins over resume
      if (auto_rts)
      begin
         if (rx_fifo_level >= halt_lvl)
            st_d.rts_act = 1'b0;
         else if (!st_q.rts_act && (rx_fifo_level <= resume_lvl))
            st_d.rts_act = 1'b1;
      end
      else
      begin
         st_d.rts_act = 1'b1;
      end
      st_d.rts_n = auto_rts ? !st_d.rts_act : !st_q.modem[MODEM_RTS];

      // Decide sending of own pause or resume characters
      if ((tx_mode != FLOW_NONE) && (st_q.send_st == SEND_IDLE))
      begin
         if (!st_q.local_paused && (rx_fifo_level > halt_lvl))
         begin
            st_d.send_st = SEND_FIRST;
            st_d.send_pause = 1'b1;
            st_d.local_paused = 1'b1;
         end
         else if (st_q.local_paused && (rx_fifo_level <= resume_lvl))
         begin
            st_d.send_st = SEND_FIRST;
            st_d.send_pause = 1'b0;
            st_d.local_paused = 1'b0;
         end
      end
      else if (tx_mode == FLOW_NONE)
      begin
         st_d.local_paused = 1'b0;
      end

      // Transmitter start; CTS looked at only when a byte is about to start
      cts_ok = !auto_cts || !cts_seen;
      if (st_q.send_pause)
         flow_char = ((st_q.send_st == SEND_SECOND) || (tx_mode == FLOW_SECOND)) ? st_q.pause2 : st_q.pause1;
      else
         flow_char = ((st_q.send_st == SEND_SECOND) || (tx_mode == FLOW_SECOND)) ? st_q.resume2 : st_q.resume1;
      if (tx_ready && !st_q.tx.start)
      begin
         if (st_q.send_st != SEND_IDLE)
         begin
            st_d.tx.start = 1'b1;
            st_d.tx.from_fifo = 1'b0;
            st_d.tx.data = flow_char & mask;
            st_d.send_st = ((st_q.send_st == SEND_FIRST) && (tx_mode == FLOW_BOTH)) ? SEND_SECOND
                           : SEND_IDLE;
         end
         else if (!tx_fifo_empty && cts_ok && !st_q.remote_paused)
         begin
            st_d.tx.start = 1'b1;
            st_d.tx.from_fifo = 1'b1;
            st_d.tx.data = 8'h00;
         end
      end

      // Receive comparison
      seq_mode = (rx_mode == FLOW_BOTH) && ((tx_mode == FLOW_NONE) || (tx_mode == FLOW_BOTH));
      use_first = (rx_mode == FLOW_FIRST) || (rx_mode == FLOW_BOTH);
      use_second = (rx_mode == FLOW_SECOND) || (rx_mode == FLOW_BOTH);
      pause_hit = 1'b0;
      resume_hit = 1'b0;
      special_hit = 1'b0;
      consume = 1'b0;
      if (rx_in.valid)
      begin
         if (seq_mode)
         begin
            if (st_q.pause_half && (rx_c == (st_q.pause2 & mask)))
            begin
               pause_hit = 1'b1;
               consume = 1'b1;
               st_d.pause_half = 1'b0;
            end
            else
            begin
               st_d.pause_half = (rx_c == (st_q.pause1 & mask));
               consume = st_d.pause_half;
            end
            if (st_q.resume_half && (rx_c == (st_q.resume2 & mask)))
            begin
               resume_hit = 1'b1;
               consume = 1'b1;
               st_d.resume_half = 1'b0;
            end
            else
            begin
               st_d.resume_half = (rx_c == (st_q.resume1 & mask));
               consume = consume || st_d.resume_half;
            end
         end
         else
         begin
            pause_hit = (use_first && (rx_c == (st_q.pause1 & mask)))
                        || (use_second && (rx_c == (st_q.pause2 & mask)));
            resume_hit = (use_first && (rx_c == (st_q.resume1 & mask)))
                         || (use_second && (rx_c == (st_q.resume2 & mask)));
            consume = pause_hit || resume_hit;
            st_d.pause_half = 1'b0;
            st_d.resume_half = 1'b0;
         end
         // Generic resume: any character but a pause ends the pause; it is stored as data unless it matches a flow character
         if (st_q.modem[MODEM_ANY_RESUME] && st_q.remote_paused && !pause_hit)
            resume_hit = 1'b1;
         if (st_q.feat[FEAT_SPECIAL] && !consume && (rx_c == (st_q.pause2 & mask)))
            special_hit = 1'b1;
         // Data keeps flowing into the FIFO whatever RTS shows
         if (!consume)
         begin
            st_d.store.valid = 1'b1;
            st_d.store.data = rx_in.data;
         end
      end

      // Remote pause state
      if (pause_hit)
         st_d.remote_paused = 1'b1;
      else if (resume_hit || (rx_mode == FLOW_NONE && !st_q.modem[MODEM_ANY_RESUME]))
         st_d.remote_paused = 1'b0;

      // Pause flag, a set in the same cycle wins over a clear
      if (iir_read && st_q.flag_special)
         st_d.flag = 1'b0;
      if (resume_hit && !st_q.flag_special)
         st_d.flag = 1'b0;
      if (pause_hit)
      begin
         st_d.flag = 1'b1;
         st_d.flag_special = 1'b0;
      end
      else if (special_hit)
      begin
         st_d.flag = 1'b1;
         st_d.flag_special = 1'b1;
      end

      // Reset keeps the four flow characters
      if (rst)
      begin
         st_d = st_t'('0);
         st_d.pause1 = st_q.pause1;
         st_d.pause2 = st_q.pause2;
         st_d.resume1 = st_q.resume1;
         st_d.resume2 = st_q.resume2;
         st_d.cts_s1 = 1'b1;
         st_d.cts_s2 = 1'b1;
         st_d.rts_act = 1'b1;
         st_d.rts_n = 1'b1;
         st_d.send_st = SEND_IDLE;
         st_d.rx_trig = LVL_ONE;
         st_d.tx_trig = LVL_ONE;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst || ce)
         st_q <= st_d;
   end

   assign rdata = st_q.rdata;
   assign tx_cmd = st_q.tx;
   assign rx_store = st_q.store;
   assign rts_n = st_q.rts_n;
   assign pause_irq_n = !(st_q.flag && st_q.irq_en[IRQ_EN_PAUSE]);
   assign modem_irq_allow = !auto_cts;
   assign rx_trig_lvl = st_q.rx_trig;
   assign tx_trig_lvl = st_q.tx_trig;

   a_reset_trig_one:
   assert property (@(posedge clk_sys) disable iff (rst)
      $past(rst) |-> (rx_trig_lvl == LVL_ONE) && (tx_trig_lvl == LVL_ONE))
      else $error("trigger level not one after reset");

   a_cts_gates_start:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && $past(ce) && tx_cmd.start && tx_cmd.from_fifo && $past(auto_cts) |-> !$past(cts_seen))
      else $error("byte started while clear to send inactive");

   a_rts_halt_drop:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && auto_rts && (rx_fifo_level >= halt_lvl) |=> rts_n)
      else $error("request to send active at halt level");

   a_rts_resume_back:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && auto_rts && rts_n && (rx_fifo_level <= resume_lvl) && (rx_fifo_level < halt_lvl) |=> !rts_n)
      else $error("request to send not restored at resume level");

   a_paused_no_data:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && st_q.remote_paused |=> !(tx_cmd.start && tx_cmd.from_fifo))
      else $error("data sent while paused by remote");

   a_resume_clears_flag:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && resume_hit && !pause_hit && !special_hit && !st_q.flag_special |=> !st_q.flag && !st_q.remote_paused)
      else $error("resume did not clear pause state");

   a_special_stored:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && special_hit |=> rx_store.valid && st_q.flag && !st_q.remote_paused)
      else $error("special character not stored or flagged");

   a_flow_char_masked:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && $past(ce) && tx_cmd.start && !tx_cmd.from_fifo |-> (tx_cmd.data & ~char_mask($past(word_len))) == 8'h00)
      else $error("flow character wider than word length");

   a_pause_sent_first:
   assert property (@(posedge clk_sys) disable iff (rst)
      ce && (tx_mode != FLOW_NONE) && (st_q.send_st == SEND_IDLE) && !st_q.local_paused
      && (rx_fifo_level > halt_lvl) |=> st_q.send_pause && (st_q.send_st == SEND_FIRST))
      else $error("pause character not queued past halt level");

endmodule : uart_flow_control

`default_nettype wire

// ---- bench/remote_uart_model.sv ----
/*
 Behavioural remote UART on the serial side of the flow-control block.
 Assumes the bench tells it when to send a character and when to block clear-to-send.
*/
`default_nettype none

module remote_uart_model
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire uart_flow_pkg::tx_cmd_t tx_cmd,
   input wire logic send_go,
   input wire logic [7:0] send_char,
   input wire logic hold,
   output logic tx_ready,
   output uart_flow_pkg::rx_char_t rx_in,
   output logic cts_n,
   output var int n_starts
);
   timeunit 1ns;
   timeprecision 1ps;
   import uart_flow_pkg::*;
   logic [2:0] busy_q;

   assign tx_ready = (busy_q == 3'h0);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         busy_q <= 3'h0;
         n_starts <= 0;
         cts_n <= 1'b0;
         rx_in <= '0;
      end
      else
      begin
         // Line busy for a few cycles per character
         if (tx_cmd.start === 1'b1)
         begin
            busy_q <= 3'h4;
            n_starts <= n_starts + 1;
         end
         else if (busy_q != 3'h0)
            busy_q <= busy_q - 3'h1;
         cts_n <= hold;
         // Idle data toggles so stale data never looks valid
         rx_in <= send_go ? '{valid: 1'b1, data: send_char} : '{valid: 1'b0, data: ~rx_in.data};
      end
   end
endmodule : remote_uart_model

`default_nettype wire

// ---- bench/tb_uart_flow_control.sv ----
/*
 Self-checking bench of uart_flow_control.
 Assumes the package and the remote model are compiled first.
*/
`default_nettype none

module tb_uart_flow_control;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_flow_pkg::*;
   logic clk_sys, rst, ce, tx_fifo_empty, cts_n, rts_n, pause_irq_n, modem_irq_allow, tx_ready, send_go, hold;
   logic [7:0] rdata, send_char, got;
   logic [1:0] word_len;
   logic [LVL_W-1:0] rx_fifo_level, rx_trig_lvl, tx_trig_lvl;
   reg_req_t req;
   tx_cmd_t tx_cmd;
   rx_char_t rx_in, rx_store;
   int n_errors, checks_done, n_starts, n_stored, s0, s1;

   uart_flow_control dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req), .rdata(rdata), .word_len(word_len),
      .rx_fifo_level(rx_fifo_level), .tx_fifo_empty(tx_fifo_empty), .tx_ready(tx_ready), .tx_cmd(tx_cmd),
      .rx_in(rx_in), .rx_store(rx_store), .cts_n(cts_n), .rts_n(rts_n), .pause_irq_n(pause_irq_n),
      .modem_irq_allow(modem_irq_allow), .rx_trig_lvl(rx_trig_lvl), .tx_trig_lvl(tx_trig_lvl));
   remote_uart_model far (.clk_sys(clk_sys), .rst(rst), .tx_cmd(tx_cmd), .send_go(send_go),
      .send_char(send_char), .hold(hold), .tx_ready(tx_ready), .rx_in(rx_in), .cts_n(cts_n), .n_starts(n_starts));

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
      if (rx_store.valid === 1'b1)
         n_stored++;

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report;
      if (n_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req <= '0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req <= '0;
      #1;
      got = rdata;
   endtask : rd

   task automatic wait_start(input int lim);
      int i;
      #1;
      for (i = 0; i < lim && tx_cmd.start !== 1'b1; i++)
         cyc(1);
      if (i == lim)
      begin
         n_errors++;
         final_report();
      end
   endtask : wait_start

   task automatic send(input logic [7:0] c);
      @(posedge clk_sys);
      send_char <= c;
      send_go <= 1'b1;
      @(posedge clk_sys);
      send_go <= 1'b0;
      cyc(4);
   endtask : send

   task automatic s_reset;
      check("rts_n", rts_n, 1'b1);
      check("irq_n", pause_irq_n, 1'b1);
      check("modem", modem_irq_allow, 1'b1);
      check("rx_trig", rx_trig_lvl, LVL_ONE);
      check("tx_trig", tx_trig_lvl, LVL_ONE);
      rd(ADDR_INTERRUPT_IDENT);
      check("ident", got, IDENT_NONE);
      wr(ADDR_PAUSE_FIRST, 8'h5A);
      wr(ADDR_ENHANCED_FEATURE, 8'h40);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(ADDR_PAUSE_FIRST);
      check("pause1", got, 8'h5A);
      rd(ADDR_ENHANCED_FEATURE);
      check("efr", got, 8'h00);
   endtask : s_reset

   task automatic s_trig;
      wr(ADDR_FIFO_CONTROL, 8'h61);
      cyc(3);
      check("rx_trig", rx_trig_lvl, RX_SEL_LVL[1]);
      check("tx_trig", tx_trig_lvl, TX_SEL_LVL[2]);
      wr(ADDR_TRIGGER_LEVEL, 8'h53);
      cyc(3);
      check("rx_trig", rx_trig_lvl, 8'h14);
      check("tx_trig", tx_trig_lvl, 8'h0C);
      wr(ADDR_TRIGGER_LEVEL, 8'h00);
   endtask : s_trig

   // Halt at 16, resume at 8, either from the nibbles or the fallback table
   task automatic s_rts(input logic [7:0] transmission_control_reg, input logic [7:0] fifo_control_reg);
      logic [6:0] lv [6] = '{7'h0F, 7'h10, 7'h11, 7'h09, 7'h08, 7'h0F};
      logic ex [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      wr(ADDR_TRANSMISSION_CONTROL, transmission_control_reg);
      wr(ADDR_FIFO_CONTROL, fifo_control_reg);
      wr(ADDR_ENHANCED_FEATURE, 8'h40);
      foreach (lv[i])
      begin
         @(posedge clk_sys) rx_fifo_level <= lv[i];
         cyc(3);
         check("rts_n", rts_n, ex[i]);
      end
      @(posedge clk_sys) rx_fifo_level <= 7'h11;
      wr(ADDR_ENHANCED_FEATURE, 8'h00);
      cyc(3);
      check("rts_n", rts_n, 1'b1);
      @(posedge clk_sys) rx_fifo_level <= 7'h00;
   endtask : s_rts

   task automatic s_cts;
      @(posedge clk_sys) hold <= 1'b1;
      wr(ADDR_ENHANCED_FEATURE, 8'h80);
      cyc(3);
      check("modem", modem_irq_allow, 1'b0);
      s0 = n_starts;
      @(posedge clk_sys) tx_fifo_empty <= 1'b0;
      cyc(20);
      check("starts", 8'(n_starts - s0), 8'h00);
      @(posedge clk_sys) hold <= 1'b0;
      wait_start(20);
      check("from_fifo", tx_cmd.from_fifo, 1'b1);
      wr(ADDR_ENHANCED_FEATURE, 8'h00);
      @(posedge clk_sys) hold <= 1'b1;
      s0 = n_starts;
      cyc(20);
      check("ignored", n_starts > s0, 1'b1);
      @(posedge clk_sys);
      tx_fifo_empty <= 1'b1;
      hold <= 1'b0;
   endtask : s_cts

   task automatic s_sw;
      @(posedge clk_sys) word_len <= 2'h0;
      wr(ADDR_PAUSE_FIRST, 8'hF3);
      wr(ADDR_RESUME_FIRST, 8'hE5);
      wr(ADDR_INTERRUPT_ENABLE, 8'h20);
      wr(ADDR_TRANSMISSION_CONTROL, 8'h24);
      wr(ADDR_ENHANCED_FEATURE, 8'h0A);
      @(posedge clk_sys) rx_fifo_level <= 7'h11;
      wait_start(20);
      check("pause_tx", tx_cmd.data, 8'h13);
      check("kind", tx_cmd.from_fifo, 1'b0);
      @(posedge clk_sys) rx_fifo_level <= 7'h08;
      wait_start(20);
      check("resume_tx", tx_cmd.data, 8'h05);
      s1 = n_stored;
      send(8'h13);
      check("irq_n", pause_irq_n, 1'b0);
      check("stored", 8'(n_stored - s1), 8'h00);
      rd(ADDR_INTERRUPT_IDENT);
      check("ident", got, IDENT_PAUSE);
      s0 = n_starts;
      @(posedge clk_sys) tx_fifo_empty <= 1'b0;
      cyc(20);
      check("starts", 8'(n_starts - s0), 8'h00);
      send(8'h05);
      cyc(20);
      check("irq_n", pause_irq_n, 1'b1);
      check("resumed", n_starts > s0, 1'b1);
      @(posedge clk_sys) tx_fifo_empty <= 1'b1;
      wr(ADDR_MODEM_CONTROL, 8'h20);
      send(8'h13);
      s1 = n_stored;
      send(8'h41);
      check("irq_n", pause_irq_n, 1'b1);
      check("stored", 8'(n_stored - s1), 8'h01);
      check("any_data", rx_store.data, 8'h41);
      wr(ADDR_MODEM_CONTROL, 8'h00);
   endtask : s_sw

   task automatic s_special;
      @(posedge clk_sys);
      word_len <= 2'h3;
      tx_fifo_empty <= 1'b0;
      wr(ADDR_PAUSE_SECOND, 8'h7E);
      wr(ADDR_ENHANCED_FEATURE, 8'h20);
      s0 = n_starts;
      s1 = n_stored;
      send(8'h7E);
      check("irq_n", pause_irq_n, 1'b0);
      check("stored", 8'(n_stored - s1), 8'h01);
      check("store_data", rx_store.data, 8'h7E);
      cyc(20);
      check("running", n_starts > s0, 1'b1);
      rd(ADDR_INTERRUPT_IDENT);
      check("ident", got, IDENT_PAUSE);
      cyc(2);
      check("irq_n", pause_irq_n, 1'b1);
   endtask : s_special

   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      req = '0;
      word_len = 2'h3;
      rx_fifo_level = '0;
      tx_fifo_empty = 1'b1;
      send_go = 1'b0;
      send_char = 8'h00;
      hold = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(1);
      s_reset();
      s_trig();
      s_rts(8'h24, 8'h01);
      s_rts(8'h00, 8'h41);
      s_cts();
      s_sw();
      s_special();
      final_report();
   end
endmodule : tb_uart_flow_control

`default_nettype wire
